// ===== core/srfe_pkg.sv
// Purpose: constants shared by the sensor read frame emitter
// Assumes: byte-wide serial API stream, 32-bit classic Wishbone slave
// Notes: frame offsets count from the start delimiter at offset 0
package srfe_pkg;
   // frame bytes and type codes
   localparam logic [7:0] START_DELIM = 8'h7E;
   localparam logic [7:0] TYPE_SENSOR = 8'h94;
   localparam logic [7:0] TYPE_NODE_ID = 8'h95;
   localparam logic [7:0] CKSUM_BASE = 8'hFF;
   localparam logic [7:0] NAME_END = 8'h00;
   // byte offsets inside a frame
   localparam logic [4:0] OFS_START = 5'h00;
   localparam logic [4:0] OFS_LEN_MSB = 5'h01;
   localparam logic [4:0] OFS_LEN_LSB = 5'h02;
   localparam logic [4:0] OFS_TYPE = 5'h03;
   localparam logic [4:0] OFS_ADDR64 = 5'h04;
   localparam logic [4:0] OFS_ADDR16 = 5'h0C;
   localparam logic [4:0] OFS_RXOPT = 5'h0E;
   localparam logic [4:0] OFS_SENSOR = 5'h0F;
   localparam logic [4:0] OFS_AD = 5'h10;
   localparam logic [4:0] OFS_TEMP = 5'h18;
   localparam logic [4:0] OFS_REMOTE = 5'h0F;
   localparam logic [4:0] OFS_NAME = 5'h11;
   localparam logic [4:0] OFS_NAME_END = 5'h15;
   // length fields and checksum positions
   localparam logic [15:0] LEN_SENSOR = 16'h0017;
   localparam logic [15:0] LEN_NODE_ID = 16'h0013;
   localparam logic [4:0] LAST_SENSOR = 5'h1A;
   localparam logic [4:0] LAST_NODE_ID = 5'h16;
   // option and content flags
   localparam logic [7:0] RXO_ACKED = 8'h01;
   localparam logic [7:0] RXO_BCAST = 8'h02;
   localparam logic [7:0] RXO_APS = 8'h20;
   localparam logic [7:0] SNS_AD = 8'h01;
   localparam logic [7:0] SNS_TEMP = 8'h02;
   localparam logic [7:0] SNS_WATER = 8'h60;
   localparam logic [15:0] TEMP_ABSENT = 16'hFFFF;
   // register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int CTRL_AO_BIT = 0;
   localparam int CTRL_JN_BIT = 1;
   localparam logic [7:0] CB_IDENTIFY = 8'h01;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // frame builder states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SENSOR = 3'b010,
      ST_NODE = 3'b100
   } srfe_state_type;
endpackage

// ===== core/srfe_emitter.sv
// Purpose: builds sensor read (0x94) and node id (0x95) API frames
// Assumes: one clock, async active-low reset, classic Wishbone slave
// Notes: bytes leave through a 16-word FIFO; TX_READY_IN stalls it
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps

module srfe_fifo
   import srfe_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
   logic [AW:0] count_ff, nxt_count;
   logic out_valid_ff, nxt_out_valid;
   logic [WIDTH-1:0] out_data_ff, nxt_out_data;
   logic push, pop;

   // memory holds DEPTH words; the output register sits in front of it
   assign in_ready_out = (count_ff != DEPTH[AW:0]);
   assign push = in_valid_in && in_ready_out;
   assign pop = (count_ff != '0) && (!out_valid_ff || out_ready_in);
   assign out_valid_out = out_valid_ff;
   assign out_data_out = out_data_ff;

   // pointer and output stage next values
   always_comb begin
      nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      nxt_out_valid = pop ? 1'b1 : (out_ready_in ? 1'b0 : out_valid_ff);
      nxt_out_data = pop ? mem[rd_ptr_ff] : out_data_ff;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         out_valid_ff <= 1'b0;
         out_data_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
         out_valid_ff <= nxt_out_valid;
         out_data_ff <= nxt_out_data;
      end
   end

   // storage needs no reset; only pointers define content
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_in;
      end
   end
endmodule

module srfe_emitter
   import srfe_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter logic JOIN_NOTIFY_RESET = 1'b0
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [3:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic SAMPLE_VALID_IN,
   input wire logic [63:0] SAMPLE_ADDR64_IN,
   input wire logic [15:0] SAMPLE_ADDR16_IN,
   input wire logic SAMPLE_ACKED_IN,
   input wire logic SAMPLE_BCAST_IN,
   input wire logic SAMPLE_APS_IN,
   input wire logic SAMPLE_AD_READ_IN,
   input wire logic SAMPLE_TEMP_READ_IN,
   input wire logic [63:0] SAMPLE_AD_IN,
   input wire logic [15:0] SAMPLE_TEMP_IN,
   input wire logic SAMPLE_TEMP_FOUND_IN,
   output logic SAMPLE_READY_OUT,
   input wire logic NID_VALID_IN,
   input wire logic [63:0] NID_ADDR64_IN,
   input wire logic [15:0] NID_ADDR16_IN,
   input wire logic NID_BCAST_IN,
   input wire logic [15:0] NID_REMOTE16_IN,
   input wire logic [31:0] NID_NAME_IN,
   output logic NID_READY_OUT,
   input wire logic WATER_DETECT_PIN_N_IN,
   input wire logic COMMISSION_BUTTON_IN,
   input wire logic JOIN_EVENT_IN,
   input wire logic ASSOCIATED_IN,
   output logic ANNOUNCE_OUT,
   output logic [7:0] TX_DATA_OUT,
   output logic TX_VALID_OUT,
   input wire logic TX_READY_IN
);
   srfe_state_type state_ff, nxt_state;
   logic [4:0] idx_ff, nxt_idx;
   logic [7:0] sum_ff, nxt_sum;
   logic ready_ff, nxt_ready;
   logic [63:0] f_addr64_ff, nxt_f_addr64;
   logic [15:0] f_addr16_ff, nxt_f_addr16;
   logic [7:0] f_opt_ff, nxt_f_opt;
   logic [7:0] f_sns_ff, nxt_f_sns;
   logic [63:0] f_ad_ff, nxt_f_ad;
   logic [15:0] f_temp_ff, nxt_f_temp;
   logic [15:0] f_remote_ff, nxt_f_remote;
   logic [31:0] f_name_ff, nxt_f_name;
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic [7:0] frames_ff, nxt_frames;
   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic announce_ff, nxt_announce;
   logic boot_pend_ff, nxt_boot_pend;
   logic [1:0] sync1_ff, sync2_ff, sync3_ff, stable_ff, nxt_stable;
   logic press_seen_ff, nxt_press_seen;
   logic sample_take, nid_take, busy, fifo_ready, push, last;
   logic wb_req, cmd_identify, water, button;
   logic [7:0] cur_byte;
   logic fifo_full;

   // two-byte value split, high byte first on the wire
   function automatic logic [7:0] hi_lo(input logic [15:0] v,
                                        input logic low);
      hi_lo = low ? v[7:0] : v[15:8];
   endfunction

   // frame content by offset; checksum byte taken from running sum
   function automatic logic [7:0] frame_byte(input logic [4:0] i,
                                             input logic node,
                                             input logic [7:0] sum);
      logic [4:0] r;
      logic [15:0] len;
      r = 5'h00;
      len = node ? LEN_NODE_ID : LEN_SENSOR;
      frame_byte = NAME_END;
      if (i == OFS_START) begin
         frame_byte = START_DELIM;
      end else if (i == OFS_LEN_MSB || i == OFS_LEN_LSB) begin
         frame_byte = hi_lo(len, i == OFS_LEN_LSB);
      end else if (i == OFS_TYPE) begin
         frame_byte = node ? TYPE_NODE_ID : TYPE_SENSOR;
      end else if (i == (node ? LAST_NODE_ID : LAST_SENSOR)) begin
         frame_byte = CKSUM_BASE - sum;
      end else if (i < OFS_ADDR16) begin
         r = i - OFS_ADDR64;
         frame_byte = f_addr64_ff[8'(63 - 8 * r) -: 8];
      end else if (i < OFS_RXOPT) begin
         frame_byte = hi_lo(f_addr16_ff, i[0]);
      end else if (i == OFS_RXOPT) begin
         frame_byte = f_opt_ff;
      end else if (node) begin
         if (i < OFS_NAME) begin
            frame_byte = hi_lo(f_remote_ff, i == OFS_NAME - 5'h01);
         end else if (i < OFS_NAME_END) begin
            r = i - OFS_NAME;
            frame_byte = f_name_ff[8'(31 - 8 * r) -: 8];
         end
      end else if (i == OFS_SENSOR) begin
         frame_byte = f_sns_ff;
      end else if (i < OFS_TEMP) begin
         r = i - OFS_AD;
         frame_byte = f_ad_ff[8'(63 - 8 * r) -: 8];
      end else begin
         frame_byte = hi_lo(f_temp_ff, i[0]);
      end
   endfunction

   // handshakes: a sample wins when both arrive together
   assign sample_take = SAMPLE_VALID_IN && ready_ff;
   assign nid_take = NID_VALID_IN && ready_ff && !sample_take;
   assign busy = (state_ff != ST_IDLE);
   assign push = busy && fifo_ready;
   assign last = (idx_ff == ((state_ff == ST_NODE) ? LAST_NODE_ID
                                                    : LAST_SENSOR));
   assign cur_byte = frame_byte(idx_ff, state_ff == ST_NODE, sum_ff);
   assign water = !stable_ff[0];
   assign button = stable_ff[1];

   // frame builder: latch fields on take, then stream bytes
   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_sum = sum_ff;
      nxt_frames = frames_ff;
      nxt_f_addr64 = f_addr64_ff;
      nxt_f_addr16 = f_addr16_ff;
      nxt_f_opt = f_opt_ff;
      nxt_f_sns = f_sns_ff;
      nxt_f_ad = f_ad_ff;
      nxt_f_temp = f_temp_ff;
      nxt_f_remote = f_remote_ff;
      nxt_f_name = f_name_ff;
      unique case (state_ff)
         ST_IDLE: begin
            nxt_idx = OFS_START;
            nxt_sum = 8'h00;
            if (sample_take) begin
               nxt_f_addr64 = SAMPLE_ADDR64_IN;
               nxt_f_addr16 = SAMPLE_ADDR16_IN;
               nxt_f_opt = (SAMPLE_ACKED_IN ? RXO_ACKED : 8'h00)
                         | (SAMPLE_BCAST_IN ? RXO_BCAST : 8'h00)
                         | (SAMPLE_APS_IN ? RXO_APS : 8'h00);
               nxt_f_sns = (SAMPLE_AD_READ_IN ? SNS_AD : 8'h00)
                         | (SAMPLE_TEMP_READ_IN ? SNS_TEMP : 8'h00)
                         | (water ? SNS_WATER : 8'h00);
               nxt_f_ad = SAMPLE_AD_IN;
               nxt_f_temp = SAMPLE_TEMP_FOUND_IN ? SAMPLE_TEMP_IN
                                                 : TEMP_ABSENT;
               // a nonzero output select swallows the sample
               if (!ctrl_ff[CTRL_AO_BIT]) begin
                  nxt_state = ST_SENSOR;
               end
            end else if (nid_take) begin
               nxt_f_addr64 = NID_ADDR64_IN;
               nxt_f_addr16 = NID_ADDR16_IN;
               nxt_f_opt = NID_BCAST_IN ? RXO_BCAST : 8'h00;
               nxt_f_remote = NID_REMOTE16_IN;
               nxt_f_name = NID_NAME_IN;
               nxt_state = ST_NODE;
            end
         end
         ST_SENSOR, ST_NODE: begin
            if (push) begin
               nxt_idx = idx_ff + 5'h01;
               if (idx_ff >= OFS_TYPE) begin
                  nxt_sum = sum_ff + cur_byte;
               end
               if (last) begin
                  nxt_state = ST_IDLE;
                  nxt_frames = frames_ff + 8'h01;
               end
            end
         end
      endcase
      nxt_ready = (nxt_state == ST_IDLE);
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_ff <= ST_IDLE;
         idx_ff <= OFS_START;
         sum_ff <= 8'h00;
         ready_ff <= 1'b0;
         frames_ff <= 8'h00;
         f_addr64_ff <= 64'h0;
         f_addr16_ff <= 16'h0;
         f_opt_ff <= 8'h00;
         f_sns_ff <= 8'h00;
         f_ad_ff <= 64'h0;
         f_temp_ff <= 16'h0;
         f_remote_ff <= 16'h0;
         f_name_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         sum_ff <= nxt_sum;
         ready_ff <= nxt_ready;
         frames_ff <= nxt_frames;
         f_addr64_ff <= nxt_f_addr64;
         f_addr16_ff <= nxt_f_addr16;
         f_opt_ff <= nxt_f_opt;
         f_sns_ff <= nxt_f_sns;
         f_ad_ff <= nxt_f_ad;
         f_temp_ff <= nxt_f_temp;
         f_remote_ff <= nxt_f_remote;
         f_name_ff <= nxt_f_name;
      end
   end

   assign SAMPLE_READY_OUT = ready_ff;
   assign NID_READY_OUT = ready_ff;

   // wishbone slave: ack one cycle after request, dropped the next
   assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_ff;
   assign cmd_identify = wb_req && WB_WE_IN && WB_SEL_IN[0]
                         && (WB_ADR_IN == REG_CMD)
                         && (WB_DAT_IN[7:0] == CB_IDENTIFY);

   always_comb begin
      nxt_ack = wb_req;
      nxt_ctrl = ctrl_ff;
      nxt_rdata = 32'h0;
      if (wb_req && WB_WE_IN && WB_SEL_IN[0]
          && WB_ADR_IN == REG_CTRL) begin
         nxt_ctrl = WB_DAT_IN[1:0];
      end
      if (wb_req && !WB_WE_IN) begin
         unique case (WB_ADR_IN)
            REG_CTRL: nxt_rdata = {30'h0, ctrl_ff};
            REG_STATUS: nxt_rdata = {16'h0, frames_ff, 4'h0,
                                     ASSOCIATED_IN, water,
                                     fifo_full, busy};
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ack_ff <= 1'b0;
         ctrl_ff <= {JOIN_NOTIFY_RESET, 1'b0};
         rdata_ff <= 32'h0;
      end else begin
         ack_ff <= nxt_ack;
         ctrl_ff <= nxt_ctrl;
         rdata_ff <= nxt_rdata;
      end
   end

   assign WB_ACK_OUT = ack_ff;
   assign WB_DAT_OUT = rdata_ff;

   // pin synchronisers: bit0 water pin, bit1 button; a change counts
   // only once the second and third stages agree
   always_comb begin
      nxt_stable = stable_ff;
      for (int b = 0; b < 2; b++) begin
         if (sync2_ff[b] == sync3_ff[b]) begin
            nxt_stable[b] = sync3_ff[b];
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sync1_ff <= 2'h1;
         sync2_ff <= 2'h1;
         sync3_ff <= 2'h1;
         stable_ff <= 2'h1;
      end else begin
         sync1_ff <= {COMMISSION_BUTTON_IN, WATER_DETECT_PIN_N_IN};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         stable_ff <= nxt_stable;
      end
   end

   // self-announce pulse; boot flag survives until association or a join event is seen with the join bit set
   always_comb begin
      nxt_press_seen = button;
      nxt_boot_pend = boot_pend_ff;
      nxt_announce = (button && !press_seen_ff) || cmd_identify;
      if (JOIN_EVENT_IN && ctrl_ff[CTRL_JN_BIT]) begin
         nxt_announce = 1'b1;
         nxt_boot_pend = 1'b0;
      end
      if (boot_pend_ff && ASSOCIATED_IN && ctrl_ff[CTRL_JN_BIT]) begin
         nxt_announce = 1'b1;
         nxt_boot_pend = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         press_seen_ff <= 1'b1; // set although the stable button bit resets to 0; no boot pulse
         boot_pend_ff <= 1'b1;
         announce_ff <= 1'b0;
      end else begin
         press_seen_ff <= nxt_press_seen;
         boot_pend_ff <= nxt_boot_pend;
         announce_ff <= nxt_announce;
      end
   end

   assign ANNOUNCE_OUT = announce_ff;

   // output FIFO; a stalled host holds the builder via fifo_ready
   srfe_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RESETN_IN),
      .in_valid_in(busy),
      .in_data_in(cur_byte),
      .in_ready_out(fifo_ready),
      .out_valid_out(TX_VALID_OUT),
      .out_data_out(TX_DATA_OUT),
      .out_ready_in(TX_READY_IN)
   );

   assign fifo_full = !fifo_ready;
endmodule

// ===== bench/srfe_host_model.sv
// Purpose: host sink on the serial API byte stream
// Assumes: one byte taken per edge with valid and ready high
// Notes: stall_in holds ready low so the FIFO can fill up
`timescale 1ns/100ps
module srfe_host_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] data_in,
   input wire logic valid_in,
   input wire logic stall_in,
   output logic ready_out
);
   logic [7:0] rx_q[$];
   // never ready while stalled, so no byte is taken then
   assign ready_out = !stall_in;
   // collect every byte taken, in arrival order
   always @(posedge clk_in) begin
      if (rst_n_in && valid_in === 1'b1 && ready_out) begin
         rx_q.push_back(data_in);
      end
   end
endmodule

// ===== bench/srfe_emitter_sva.sv
// Purpose: port checks for the frame emitter
// Assumes: bound to srfe_emitter, sees only its ports
// Notes: frame position tracked from the taken bytes alone
`timescale 1ns/100ps
module srfe_emitter_sva
   import srfe_pkg::*;
#(
   parameter logic JOIN_NOTIFY_RESET = 1'b0
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [3:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic WB_ACK_OUT,
   input wire logic SAMPLE_VALID_IN,
   input wire logic SAMPLE_READY_OUT,
   input wire logic JOIN_EVENT_IN,
   input wire logic ANNOUNCE_OUT,
   input wire logic [7:0] TX_DATA_OUT,
   input wire logic TX_VALID_OUT,
   input wire logic TX_READY_IN
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   logic take, wr, ao_ff, jn_ff, nxt_ao, nxt_jn;
   logic [4:0] pos_ff, nxt_pos;
   logic [7:0] len_ff, sum_ff, nxt_len, nxt_sum;
   assign take = TX_VALID_OUT & TX_READY_IN;
   assign wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & !WB_ACK_OUT & WB_SEL_IN[0];
   // shadow of the control bits and frame position; a reset mid-frame
   // restarts the count because the FIFO is cleared as well
   always_comb begin
      nxt_ao = ao_ff;
      nxt_jn = jn_ff;
      nxt_pos = pos_ff;
      nxt_len = len_ff;
      nxt_sum = sum_ff;
      if (wr && WB_ADR_IN == REG_CTRL) begin
         nxt_ao = WB_DAT_IN[CTRL_AO_BIT];
         nxt_jn = WB_DAT_IN[CTRL_JN_BIT];
      end
      if (take) begin
         nxt_pos = pos_ff + 5'h01;
         if (pos_ff == 5'h02) nxt_len = TX_DATA_OUT;
         if (pos_ff == 5'h02) nxt_sum = 8'h00;
         else nxt_sum = sum_ff + TX_DATA_OUT;
         if (pos_ff > 5'h02 && {3'h0, pos_ff} == len_ff + 8'h03) begin
            nxt_pos = 5'h00;
         end
      end
   end
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ao_ff <= 1'b0;
         jn_ff <= JOIN_NOTIFY_RESET;
         pos_ff <= 5'h00;
         len_ff <= 8'h00;
         sum_ff <= 8'h00;
      end else begin
         ao_ff <= nxt_ao;
         jn_ff <= nxt_jn;
         pos_ff <= nxt_pos;
         len_ff <= nxt_len;
         sum_ff <= nxt_sum;
      end
   end
   sequence ack_pulse_s;
      WB_ACK_OUT ##1 !WB_ACK_OUT;
   endsequence
   sequence announce_soon_s;
      ##[1:2] ANNOUNCE_OUT;
   endsequence
   wb_ack_once_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
      |=> ack_pulse_s) else $error("bus ack not a single pulse");
   frame_start_a: assert property (take && pos_ff == 5'h00 |->
      TX_DATA_OUT == START_DELIM) else $error("bad start byte");
   len_high_a: assert property (take && pos_ff == 5'h01 |->
      TX_DATA_OUT == 8'h00) else $error("bad length msb");
   type_len_a: assert property (take && pos_ff == 5'h03 |->
      (TX_DATA_OUT == TYPE_SENSOR && len_ff == LEN_SENSOR[7:0]) ||
      (TX_DATA_OUT == TYPE_NODE_ID && len_ff == LEN_NODE_ID[7:0]))
      else $error("type and length disagree");
   cksum_ok_a: assert property (take && pos_ff > 5'h03 &&
      {3'h0, pos_ff} == len_ff + 8'h03 |-> TX_DATA_OUT == CKSUM_BASE - sum_ff)
      else $error("bad checksum");
   tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN |=>
      TX_VALID_OUT && $stable(TX_DATA_OUT)) else $error("byte dropped");
   sample_taken_a: assert property (SAMPLE_VALID_IN && SAMPLE_READY_OUT
      && !ao_ff |=> !SAMPLE_READY_OUT) else $error("sample not framed");
   sample_drop_a: assert property (SAMPLE_VALID_IN && SAMPLE_READY_OUT
      && ao_ff |=> SAMPLE_READY_OUT) else $error("sample framed with ao");
   cmd_announce_a: assert property (wr && WB_ADR_IN == REG_CMD &&
      WB_DAT_IN[7:0] == CB_IDENTIFY |-> announce_soon_s)
      else $error("command did not announce");
   join_announce_a: assert property (JOIN_EVENT_IN && jn_ff |->
      announce_soon_s) else $error("join did not announce");
endmodule

// ===== bench/test_srfe_emitter.sv
// Purpose: self-checking bench for the frame emitter
// Assumes: default parameters, host model as stream sink
// Notes: expected frames are rebuilt byte by byte from the fields
`timescale 1ns/100ps
module test_srfe_emitter
   import srfe_pkg::*;
;
   logic CORE_CLK_IN = 0, RESETN_IN = 0, WB_CYC_IN = 0, WB_STB_IN = 0;
   logic WB_WE_IN = 0, WB_ACK_OUT, SAMPLE_VALID_IN = 0, SAMPLE_ACKED_IN = 0;
   logic [3:0] WB_ADR_IN = 0, WB_SEL_IN = 0;
   logic [31:0] WB_DAT_IN = 0, WB_DAT_OUT, r;
   logic [63:0] SAMPLE_ADDR64_IN = 0, SAMPLE_AD_IN = 0, NID_ADDR64_IN = 0;
   logic [15:0] SAMPLE_ADDR16_IN = 0, SAMPLE_TEMP_IN = 0, NID_ADDR16_IN = 0;
   logic [15:0] NID_REMOTE16_IN = 0;
   logic [31:0] NID_NAME_IN = 0;
   logic SAMPLE_BCAST_IN = 0, SAMPLE_APS_IN = 0, SAMPLE_AD_READ_IN = 0;
   logic SAMPLE_TEMP_READ_IN = 0, SAMPLE_TEMP_FOUND_IN = 0, SAMPLE_READY_OUT;
   logic NID_VALID_IN = 0, NID_BCAST_IN = 0, NID_READY_OUT;
   logic WATER_DETECT_PIN_N_IN = 1, COMMISSION_BUTTON_IN = 0;
   logic JOIN_EVENT_IN = 0, ASSOCIATED_IN = 0, ANNOUNCE_OUT;
   logic [7:0] TX_DATA_OUT, last_b;
   logic TX_VALID_OUT, TX_READY_IN, stall = 0;
   logic [7:0] exp[$];
   int mismatches = 0, num_checks = 0, ann = 0, a0;
   srfe_emitter i_srfe_emitter (.*);
   srfe_host_model i_srfe_host_model (.clk_in(CORE_CLK_IN),
      .rst_n_in(RESETN_IN), .data_in(TX_DATA_OUT), .valid_in(TX_VALID_OUT),
      .stall_in(stall), .ready_out(TX_READY_IN));
   always #12.5 CORE_CLK_IN = !CORE_CLK_IN;
   // announce pulses are counted, not timed, to stay latency-neutral
   always @(posedge CORE_CLK_IN) if (ANNOUNCE_OUT === 1'b1) ann <= ann + 1;
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one classic cycle; held until ack is sampled at an edge
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge CORE_CLK_IN);
      {WB_CYC_IN, WB_STB_IN, WB_WE_IN} <= {2'b11, we};
      WB_ADR_IN <= a;
      WB_DAT_IN <= d;
      WB_SEL_IN <= 4'hF;
      do @(posedge CORE_CLK_IN); while (WB_ACK_OUT !== 1'b1);
      r = WB_DAT_OUT;
      {WB_CYC_IN, WB_STB_IN} <= 2'b00;
   endtask
   task add(input logic [7:0] b);
      exp.push_back(b);
   endtask
   task add16(input logic [15:0] v);
      add(v[15:8]);
      add(v[7:0]);
   endtask
   task add64(input logic [63:0] v);
      for (int i = 7; i >= 0; i--) add(v[i*8+:8]);
   endtask
   task head(input logic [7:0] t);
      exp.delete();
      add(START_DELIM);
      add(8'h00);
      add(8'h00);
      add(t);
   endtask
   // fills length and checksum, then compares what the host took
   task expect_frame;
      logic [7:0] s;
      int n;
      s = 8'h00;
      n = 0;
      exp[2] = 8'(exp.size() - 3);
      for (int i = 3; i < exp.size(); i++) s = s + exp[i];
      add(CKSUM_BASE - s);
      while (i_srfe_host_model.rx_q.size() < exp.size() && n < 600) begin
         @(posedge CORE_CLK_IN);
         n++;
      end
      foreach (exp[i]) chk(i_srfe_host_model.rx_q[i], exp[i]);
      last_b = i_srfe_host_model.rx_q[exp.size() - 1];
      repeat (exp.size()) void'(i_srfe_host_model.rx_q.pop_front());
   endtask
   task sample(input logic [63:0] a64, input logic [15:0] a16,
      input logic [2:0] o, input logic [1:0] rd, input logic [63:0] ad,
      input logic [15:0] t, input logic f);
      head(TYPE_SENSOR);
      add64(a64);
      add16(a16);
      add((o[0] ? RXO_ACKED : 8'h00) | (o[1] ? RXO_BCAST : 8'h00) |
         (o[2] ? RXO_APS : 8'h00));
      add((rd[0] ? SNS_AD : 8'h00) | (rd[1] ? SNS_TEMP : 8'h00) |
         (WATER_DETECT_PIN_N_IN ? 8'h00 : SNS_WATER));
      add64(ad);
      add16(f ? t : TEMP_ABSENT);
      @(posedge CORE_CLK_IN);
      {SAMPLE_APS_IN, SAMPLE_BCAST_IN, SAMPLE_ACKED_IN} <= o;
      {SAMPLE_TEMP_READ_IN, SAMPLE_AD_READ_IN} <= rd;
      {SAMPLE_ADDR64_IN, SAMPLE_ADDR16_IN, SAMPLE_AD_IN} <= {a64, a16, ad};
      {SAMPLE_TEMP_IN, SAMPLE_TEMP_FOUND_IN, SAMPLE_VALID_IN} <= {t, f, 1'b1};
      do @(posedge CORE_CLK_IN); while (SAMPLE_READY_OUT !== 1'b1);
      SAMPLE_VALID_IN <= 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge CORE_CLK_IN);
      mismatches++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge CORE_CLK_IN);
      RESETN_IN <= 1'b1;
      repeat (2) @(posedge CORE_CLK_IN);
      wb(0, REG_CTRL, 0);
      chk(r, 0);
      wb(0, 4'hC, 0);
      chk(r, 0);
      stall <= 1'b1;
      sample(64'h0013A20040522BAA, 16'hDD6C, 3'b001, 2'b11,
         64'h000200CE00EA0052, 16'h016A, 1'b1);
      repeat (60) @(posedge CORE_CLK_IN);
      chk(SAMPLE_READY_OUT, 0);
      stall <= 1'b0;
      expect_frame();
      chk(last_b, 8'h8B);
      WATER_DETECT_PIN_N_IN <= 1'b0;
      repeat (8) @(posedge CORE_CLK_IN);
      sample(64'hFEDCBA9876543210, 16'h8001, 3'b111, 2'b01,
         64'hFFFF0001800012AB, 16'h1234, 1'b0);
      expect_frame();
      wb(1, REG_CTRL, 1);
      sample(64'h1, 16'h2, 3'b000, 2'b10, 64'h3, 16'h4, 1'b1);
      repeat (40) @(posedge CORE_CLK_IN);
      chk(i_srfe_host_model.rx_q.size(), 0);
      wb(1, REG_CTRL, 0);
      head(TYPE_NODE_ID);
      add64(64'h0102030405060708);
      add16(16'hBEEF);
      add(RXO_BCAST);
      add16(16'hCAFE);
      add64({32'h4E4F4445, 32'h0});
      void'(exp.pop_back());
      void'(exp.pop_back());
      void'(exp.pop_back());
      @(posedge CORE_CLK_IN);
      {NID_ADDR64_IN, NID_ADDR16_IN, NID_BCAST_IN} <=
         {64'h0102030405060708, 16'hBEEF, 1'b1};
      {NID_REMOTE16_IN, NID_NAME_IN, NID_VALID_IN} <=
         {16'hCAFE, 32'h4E4F4445, 1'b1};
      do @(posedge CORE_CLK_IN); while (NID_READY_OUT !== 1'b1);
      NID_VALID_IN <= 1'b0;
      expect_frame();
      a0 = ann;
      wb(1, REG_CMD, {24'h0, CB_IDENTIFY});
      repeat (4) @(posedge CORE_CLK_IN);
      chk(ann, a0 + 1);
      COMMISSION_BUTTON_IN <= 1'b1;
      repeat (10) @(posedge CORE_CLK_IN);
      chk(ann, a0 + 2);
      wb(1, REG_CTRL, 2);
      ASSOCIATED_IN <= 1'b1;
      repeat (4) @(posedge CORE_CLK_IN);
      chk(ann, a0 + 3);
      JOIN_EVENT_IN <= 1'b1;
      @(posedge CORE_CLK_IN);
      JOIN_EVENT_IN <= 1'b0;
      repeat (4) @(posedge CORE_CLK_IN);
      chk(ann, a0 + 4);
      // three frames built, idle, water present, associated
      wb(0, REG_STATUS, 0);
      chk(r, 32'h0000030C);
      close_out();
   end
endmodule
bind srfe_emitter srfe_emitter_sva #(.JOIN_NOTIFY_RESET(JOIN_NOTIFY_RESET))
   i_srfe_emitter_sva (.*);
